//--- shared/ssv_cfg.svh
`ifndef SSV_CFG_SVH
`define SSV_CFG_SVH

// ----------------------------------------
// Register map and field positions
// ----------------------------------------
`define SSV_REG_SYNC_CTRL     8'h0E
`define SSV_REG_THRESHOLD     8'h0F
`define SSV_BIT_VSRC_SEL      0
`define SSV_BIT_VSRC_OVR      1
`define SSV_BIT_HSRC_SEL      3
`define SSV_CTRL_RESET        8'h00
`define SSV_THRESH_RESET      8'h20

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSV_CORE_CLK_KHZ      10000
`define SSV_TICK_KHZ          5000
`define SSV_TICK_DIV          (`SSV_CORE_CLK_KHZ / `SSV_TICK_KHZ)
`define SSV_ACT_WINDOW        16'hFFFF

`endif

//--- shared/ssv_pkg.sv
`default_nettype none

package ssv_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		SSV_SEARCH = 2'b01,
		SSV_IN_VS  = 2'b10
	} ssv_state_t;

	typedef struct packed
	{
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ssv_reg_wr_t;

	typedef struct packed
	{
		logic hsync;
		logic vsync;
		logic active_vertical_source_flag;
		logic sep_vs;
	} ssv_sync_out_t;

endpackage : ssv_pkg

`default_nettype wire

//--- design/ssv_sync_sep.sv
// How it works
// - Control bit 3 chooses separate hsync (0) or green-channel sync (1).
// - Control bit 0 chooses vsync pin (0) or separator output (1).
// - Separator is an 8-bit counter stepped by a 5 MHz tick.
// - Separator counts active-high sync only; csync_norm must be polarity-normalised upstream.
// - Searching, counter rises each tick while sync pulse is active.
// - After a pulse the counter falls each tick and stops at zero.
// - Vsync declared when counter exceeds the programmed threshold register.
// - On detection clear counter, then count up while sync is inactive.
// - Vsync ended when absence count reaches threshold, rejecting serrations.
// - After end, clear counter and return to searching.
// - Override bit 1 forces active source flag to control bit 0.
// - Without override, flag follows vsync pin activity: 1 while a pin edge has been seen within the activity window, else 0.
`timescale 1ns/1ps
`default_nettype none
`include "ssv_cfg.svh"

module ssv_sync_sep
#(
	parameter int ACT_W = 16
)
(
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire ssv_pkg::ssv_reg_wr_t  reg_wr,
	input  wire logic [7:0]            reg_raddr,
	output logic [7:0]                 reg_rdata,
	input  wire logic                  hsync_in,
	input  wire logic                  green_channel_sync_input,
	input  wire logic                  vsync_in,
	input  wire logic                  csync_norm,
	output ssv_pkg::ssv_sync_out_t     sync_out
);

	// ----------------------------------------
	// Registers and synchronisers
	// ----------------------------------------
	logic [7:0]             ctrl_q, ctrl_d;
	logic [7:0]             thr_q, thr_d;
	logic [3:0]             s1_q, s2_q;
	logic                   vs_prev_q;
	logic [ACT_W-1:0]       act_cnt_q, act_cnt_d;
	logic                   vs_act_q, vs_act_d;
	logic [1:0]             div_q, div_d;
	logic                   tick_q, tick_d;
	logic [7:0]             cnt_q, cnt_d;
	ssv_pkg::ssv_state_t    st_q, st_d;
	ssv_pkg::ssv_sync_out_t out_d;
	logic [7:0]             rdata_d;

	logic hs_s, green_s, vs_s, cs_s;
	assign {hs_s, green_s, vs_s, cs_s} = s2_q;

	// Saturating increment keeps long pulses pinned at the top.
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		sat_inc = (v == 8'hFF) ? v : v + 8'h01;
	endfunction : sat_inc

	// Register writes steer the muxes and the separator threshold.
	always_comb
	begin
		ctrl_d = ctrl_q;
		thr_d  = thr_q;
		if (reg_wr.we && reg_wr.addr == `SSV_REG_SYNC_CTRL)
			ctrl_d = reg_wr.wdata;
		if (reg_wr.we && reg_wr.addr == `SSV_REG_THRESHOLD)
			thr_d = reg_wr.wdata;
		case (reg_raddr)
			`SSV_REG_SYNC_CTRL: rdata_d = ctrl_q;
			`SSV_REG_THRESHOLD: rdata_d = thr_q;
			default:            rdata_d = 8'h00;
		endcase
	end

	// Tick divider: one-cycle enable at the 5 MHz count rate.
	always_comb
	begin
		div_d  = div_q;
		tick_d = 1'b0;
		if (div_q == 2'(`SSV_TICK_DIV - 1))
		begin
			div_d  = 2'h0;
			tick_d = 1'b1;
		end
		else
			div_d = div_q + 2'h1;
	end

	// Vsync pin activity: an edge seen within the window counts as active.
	always_comb
	begin
		act_cnt_d = act_cnt_q;
		vs_act_d  = vs_act_q;
		if (vs_s != vs_prev_q)
		begin
			act_cnt_d = '0;
			vs_act_d  = 1'b1;
		end
		else if (act_cnt_q == ACT_W'(`SSV_ACT_WINDOW))
			vs_act_d = 1'b0;
		else
			act_cnt_d = act_cnt_q + ACT_W'(1);
	end

	// Separator: csync_norm is already polarity-normalised upstream.
	always_comb
	begin
		cnt_d = cnt_q;
		st_d  = st_q;
		if (tick_q)
		begin
			case (st_q)
				ssv_pkg::SSV_SEARCH:
				begin
					if (cnt_q > thr_q)
					begin
						st_d  = ssv_pkg::SSV_IN_VS;
						cnt_d = 8'h00;
					end
					else if (cs_s)
						cnt_d = sat_inc(cnt_q);
					else if (cnt_q != 8'h00)
						cnt_d = cnt_q - 8'h01;
				end
				ssv_pkg::SSV_IN_VS:
				begin
					if (cnt_q >= thr_q)
					begin
						st_d  = ssv_pkg::SSV_SEARCH;
						cnt_d = 8'h00;
					end
					else if (!cs_s)
						cnt_d = sat_inc(cnt_q);
				end
				default:
				begin
					st_d  = ssv_pkg::SSV_SEARCH;
					cnt_d = 8'h00;
				end
			endcase
		end
	end

	// Output muxes and active source flag.
	always_comb
	begin
		out_d.sep_vs = (st_d == ssv_pkg::SSV_IN_VS);
		out_d.hsync  = ctrl_q[`SSV_BIT_HSRC_SEL] ? green_s : hs_s;
		out_d.vsync  = ctrl_q[`SSV_BIT_VSRC_SEL] ? out_d.sep_vs : vs_s;
		if (ctrl_q[`SSV_BIT_VSRC_OVR])
			out_d.active_vertical_source_flag = ctrl_q[`SSV_BIT_VSRC_SEL];
		else
			out_d.active_vertical_source_flag = vs_act_q;
	end

	// State registers.
	always_ff @(posedge core_clk)
	begin
		s1_q      <= {hsync_in, green_channel_sync_input, vsync_in, csync_norm};
		s2_q      <= s1_q;
		// The edge reference tracks the pin through reset, so a pin idling high
		// does not look like activity on the first cycle afterwards.
		vs_prev_q <= vs_s;
		if (srst)
		begin
			ctrl_q    <= `SSV_CTRL_RESET;
			thr_q     <= `SSV_THRESH_RESET;
			act_cnt_q <= '0;
			vs_act_q  <= 1'b0;
			div_q     <= 2'h0;
			tick_q    <= 1'b0;
			cnt_q     <= 8'h00;
			st_q      <= ssv_pkg::SSV_SEARCH;
			sync_out  <= '0;
			reg_rdata <= 8'h00;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			thr_q     <= thr_d;
			act_cnt_q <= act_cnt_d;
			vs_act_q  <= vs_act_d;
			div_q     <= div_d;
			tick_q    <= tick_d;
			cnt_q     <= cnt_d;
			st_q      <= st_d;
			sync_out  <= out_d;
			reg_rdata <= rdata_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Entry into and exit from the vertical interval, each a step between states.
	sequence s_vs_found;
		st_q == ssv_pkg::SSV_SEARCH ##1 st_q == ssv_pkg::SSV_IN_VS;
	endsequence
	sequence s_vs_lost;
		st_q == ssv_pkg::SSV_IN_VS ##1 st_q == ssv_pkg::SSV_SEARCH;
	endsequence

	a_cnt_no_wrap: assert property (@(posedge core_clk) disable iff (srst)
		cnt_q == 8'hFF && st_q == ssv_pkg::SSV_SEARCH && cs_s && tick_q && thr_q == 8'hFF
		|=> cnt_q == 8'hFF)
		else $error("Separator counter wrapped.");
	a_tick_rate: assert property (@(posedge core_clk) disable iff (srst)
		tick_q |=> !tick_q ##1 tick_q)
		else $error("Tick not at half the core rate.");
	a_cnt_floor: assert property (@(posedge core_clk) disable iff (srst)
		st_q == ssv_pkg::SSV_SEARCH && tick_q && !cs_s && cnt_q == 8'h00
		|=> cnt_q == 8'h00)
		else $error("Counter went below zero.");
	a_detect_clear: assert property (@(posedge core_clk) disable iff (srst)
		s_vs_found |-> cnt_q == 8'h00)
		else $error("Counter not cleared on detection.");
	a_end_clear: assert property (@(posedge core_clk) disable iff (srst)
		s_vs_lost |-> cnt_q == 8'h00)
		else $error("Counter not cleared on end.");
	a_sep_hold: assert property (@(posedge core_clk) disable iff (srst)
		!srst |=> sync_out.sep_vs == (st_q == ssv_pkg::SSV_IN_VS))
		else $error("Recovered vsync not tracking state.");
	a_hs_mux: assert property (@(posedge core_clk) disable iff (srst)
		!srst |=> sync_out.hsync ==
		($past(ctrl_q[`SSV_BIT_HSRC_SEL]) ? $past(green_s) : $past(hs_s)))
		else $error("Hsync mux wrong.");
	a_src_override: assert property (@(posedge core_clk) disable iff (srst)
		!srst && ctrl_q[`SSV_BIT_VSRC_OVR]
		|=> sync_out.active_vertical_source_flag == $past(ctrl_q[`SSV_BIT_VSRC_SEL]))
		else $error("Override not honoured.");
	a_src_auto: assert property (@(posedge core_clk) disable iff (srst)
		!srst && !ctrl_q[`SSV_BIT_VSRC_OVR]
		|=> sync_out.active_vertical_source_flag == $past(vs_act_q))
		else $error("Auto source select wrong.");

endmodule : ssv_sync_sep

`default_nettype wire

//--- tb/ssv_sync_source.sv
`timescale 1ns/1ps
`default_nettype none

// Graphics source model: sends one composite sync pulse of a chosen length.
module ssv_sync_source
(
	input  wire logic       core_clk,
	input  wire logic       go,
	input  wire logic [7:0] len,
	output logic            csync
);
	logic [7:0] left_q = 8'h00;

	// Loads the pulse length and counts it down; sync is high while it runs.
	always_ff @(posedge core_clk)
	begin
		if (go)
			left_q <= len;
		else if (left_q != 8'h00)
			left_q <= left_q - 8'h01;
	end

	assign csync = (left_q != 8'h00);
endmodule : ssv_sync_source

`default_nettype wire

//--- tb/test_sync_select_and_vsync_separator.sv
`timescale 1ns/1ps
`default_nettype none

module test_sync_select_and_vsync_separator;
	logic                   core_clk, srst, hsync_in, green_in, vsync_in, csync, go;
	logic [7:0]             reg_raddr, reg_rdata, plen;
	ssv_pkg::ssv_reg_wr_t   reg_wr;
	ssv_pkg::ssv_sync_out_t sync_out;
	int                     mismatches, check_count, cycles;

	ssv_sync_sep ssv_sync_sep_inst (.core_clk(core_clk), .srst(srst), .reg_wr(reg_wr),
		.reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .hsync_in(hsync_in),
		.green_channel_sync_input(green_in), .vsync_in(vsync_in), .csync_norm(csync),
		.sync_out(sync_out));
	ssv_sync_source ssv_sync_source_inst (.core_clk(core_clk), .go(go), .len(plen), .csync(csync));

	// Clock and hang guard.
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= '{we: 1'b1, addr: a, wdata: d};
		@(posedge core_clk);
		reg_wr.we <= 1'b0;
		repeat (3) @(negedge core_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_raddr <= a;
		repeat (2) @(negedge core_clk);
		chk(reg_rdata, exp);
	endtask : rd

	task automatic pulse(input logic [7:0] n);
		@(posedge core_clk);
		go <= 1'b1;
		plen <= n;
		@(posedge core_clk);
		go <= 1'b0;
	endtask : pulse

	task automatic wait_sep(input logic e, input int lim);
		int n;
		n = 0;
		while (sync_out.sep_vs !== e && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(sync_out.sep_vs, e);
	endtask : wait_sep

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	// Main sequence.
	initial
	begin
		{srst, hsync_in, green_in, vsync_in, go} = 5'h10;
		reg_wr = '0;
		{reg_raddr, plen, mismatches, check_count, cycles} = '0;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'h0E, 8'h00);
		rd(8'h0F, 8'h20);
		rd(8'h10, 8'h00);
		wr(8'h0F, 8'h04);
		wr(8'h22, 8'hFF);
		rd(8'h0F, 8'h04);
		chk(sync_out.active_vertical_source_flag, 1'b0);
		@(posedge core_clk);
		hsync_in <= 1'b1;
		wr(8'h0E, 8'h00);
		chk(sync_out.hsync, 1'b1);
		wr(8'h0E, 8'h08);
		chk(sync_out.hsync, 1'b0);
		@(posedge core_clk);
		green_in <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk(sync_out.hsync, 1'b1);
		@(posedge core_clk);
		vsync_in <= 1'b1;
		wr(8'h0E, 8'h00);
		chk(sync_out.vsync, 1'b1);
		chk(sync_out.active_vertical_source_flag, 1'b1);
		wr(8'h0E, 8'h02);
		chk(sync_out.active_vertical_source_flag, 1'b0);
		wr(8'h0E, 8'h03);
		chk(sync_out.active_vertical_source_flag, 1'b1);
		wr(8'h0E, 8'h01);
		chk(sync_out.vsync, 1'b0);
		repeat (4)
		begin
			pulse(8'd7);
			repeat (30) @(negedge core_clk);
			chk(sync_out.sep_vs, 1'b0);
		end
		pulse(8'd60);
		wait_sep(1'b1, 30);
		repeat (20) @(negedge core_clk);
		chk(sync_out.sep_vs, 1'b1);
		chk(sync_out.vsync, 1'b1);
		while (csync) @(negedge core_clk);
		repeat (3) @(negedge core_clk);
		pulse(8'd20);
		repeat (26) @(negedge core_clk);
		chk(sync_out.sep_vs, 1'b1);
		wait_sep(1'b0, 30);
		pulse(8'd60);
		wait_sep(1'b1, 30);
		wait_sep(1'b0, 90);
		// A sync held for 265 ticks, just past 255, pins the counter at its top.
		wr(8'h0F, 8'hFF);
		@(posedge core_clk);
		go   <= 1'b1;
		plen <= 8'hFF;
		repeat (530) @(negedge core_clk);
		chk(sync_out.sep_vs, 1'b0);
		wr(8'h0F, 8'hFE);
		wait_sep(1'b1, 8);
		@(posedge core_clk);
		go <= 1'b0;
		wait_sep(1'b0, 900);
		final_report();
	end
endmodule : test_sync_select_and_vsync_separator

`default_nettype wire
